//--- hdl/cpm_cfg.svh
// constants for the cpu clock and power manager
`ifndef CPM_CFG_SVH
`define CPM_CFG_SVH

// power control register bit positions
`define CPM_PCTL_LIGHT_SLEEP_BIT  0
`define CPM_PCTL_DEEP_SLEEP_BIT   1
`define CPM_PCTL_POWER_ON_BIT     4
`define CPM_PCTL_BROWNOUT_BIT     5
// auxiliary control one bit positions
`define CPM_AUX1_BO_IRQ_BIT       5
`define CPM_AUX1_BO_DISABLE_BIT   6
// machine cycle lengths in cpu clocks
`define CPM_CLKS_PER_MC_FAST      6
`define CPM_CLKS_PER_MC_LEGACY    12
// oscillator stability counts in clocks
`define CPM_OSC_WAIT_CRYSTAL      11'h400
`define CPM_OSC_WAIT_RC           11'h100
// divider reset value
`define CPM_DIVIDER_RESET         8'h00

`endif

//--- hdl/cpm_pkg.sv
// types for the cpu clock and power manager
package cpm_pkg;

    typedef enum logic [1:0] {
        CPM_RUN   = 2'b00,
        CPM_IDLE  = 2'b01,
        CPM_DOWN  = 2'b10,
        CPM_WAKE  = 2'b11
    } cpm_state_e;

    typedef struct packed {
        logic       brownout_disable;
        logic       brownout_irq_select;
    } cpm_aux_s;

    typedef struct packed {
        logic       global_int_enable;
        logic       brownout_int_enable;
    } cpm_ien_s;

    typedef struct packed {
        logic       brownout_flag;
        logic       power_on_flag;
        logic       deep_sleep_request;
        logic       light_sleep_request;
    } cpm_pctl_s;

endpackage

//--- hdl/cpm_clk_div.sv
// cpu clock enable generator: legacy halving and programmable divider
`timescale 1ns/1ps
`default_nettype none
`include "cpm_cfg.svh"

module cpm_clk_div (
    input  wire logic       sys_clk,                   // oscillator clock
    input  wire logic       rst,                       // sync reset
    input  wire logic       run,                       // oscillator running
    input  wire logic       legacy_timing_select,      // halve cpu clock
    input  wire logic [7:0] cpu_clock_divider_value,   // divider value n
    output logic            cpu_clk_en                 // one pulse per cpu clock
);

    // ----------------------------------------
    // divider counter
    // ----------------------------------------
    logic [8:0] cnt_ff;
    logic [8:0] term_ff;
    logic [8:0] nxt_term;

    // divide ratio minus one; n>0 gives 2*(n+1), doubled again in legacy
    always_comb begin
        if (cpu_clock_divider_value == 8'h00) begin
            nxt_term = 9'h000; // RULE_03
        end else begin
            nxt_term = {cpu_clock_divider_value, 1'b1}; // RULE_04
        end
    end

    // terminal count is only reloaded at a boundary so no pulse is cut short
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_ff  <= 9'h000;
            term_ff <= 9'h000;
        end else if (run) begin
            if (cnt_ff >= term_ff) begin
                cnt_ff  <= 9'h000;
                term_ff <= nxt_term; // RULE_24 RULE_05
            end else begin
                cnt_ff <= cnt_ff + 9'h001;
            end
        end
    end

    // ----------------------------------------
    // legacy halving
    // ----------------------------------------
    logic half_ff;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            half_ff <= 1'b0;
        end else if (run && cnt_ff >= term_ff && legacy_timing_select) begin
            half_ff <= ~half_ff; // RULE_01
        end
    end

    // peripherals take the same enable, so timer rates follow too
    assign cpu_clk_en = run && (cnt_ff >= term_ff) && (!legacy_timing_select || half_ff); // RULE_01 RULE_02

endmodule
`default_nettype wire

//--- hdl/cpm_top.sv
// cpu clock and power manager top
// Summary of operation
// RULE_01: legacy bit halves cpu clock, 12-clock cycles
// RULE_02: halving also slows peripheral timing
// RULE_03: divider zero passes oscillator clock
// RULE_04: divider n divides by 2*(n+1)
// RULE_05: divider changes never stall execution
// RULE_06: brownout resets, or interrupts when selected
// RULE_07: reset held while detector stays asserted
// RULE_08: one interrupt on detector rising edge
// RULE_09: brownout irq needs global and local enables
// RULE_10: brownout sets sticky flag, software clears
// RULE_11: brownout disable kills reset and interrupt
// RULE_12: power-on sets sticky flag, software clears
// RULE_13: light sleep request enters idle
// RULE_14: idle ends on enabled interrupt or reset
// RULE_15: deep sleep request stops oscillator
// RULE_16: power down exits on reset or wake irq
// RULE_17: watchdog may reset during power down
// RULE_18: brownout in power down resets or wakes
// RULE_19: wake waits 1024 or 256 clocks
// RULE_20: brownout, watchdog, analog stay on in power down
// RULE_21: software prefers reset wake after retention
// RULE_22: sleep request bits self-clear on exit
// RULE_23: brownout flag bit 5, power-on bit 4
// RULE_24: divider changes land on clock boundary
`timescale 1ns/1ps
`default_nettype none
`include "cpm_cfg.svh"

module cpm_top (
    input  wire logic                  sys_clk,                  // oscillator clock
    input  wire logic                  rst,                      // sync reset
    input  wire logic                  power_on_detect,          // power-on detector pulse
    input  wire logic                  brownout_detect,          // brownout detector level
    input  wire logic                  watchdog_overflow,        // watchdog overflow pulse
    input  wire logic                  osc_is_crystal,           // crystal oscillator option
    input  wire logic                  legacy_timing_select,     // config: 12-clock cycles
    input  wire logic [7:0]            cpu_clock_divider_value,  // divider value
    input  wire cpm_pkg::cpm_aux_s     auxiliary_control_one,    // brownout controls
    input  wire cpm_pkg::cpm_ien_s     interrupt_enable_zero,    // interrupt enables
    input  wire logic                  pctl_wr,                  // power control write strobe
    input  wire logic [7:0]            pctl_wdata,               // power control write data
    input  wire logic                  enabled_irq_pending,      // any enabled irq pending
    input  wire logic                  wake_irq_pending,         // wake irq, enabled, above level
    output logic [7:0]                 power_control_reg,        // power control readback
    output cpm_pkg::cpm_pctl_s         pctl_status,              // flag and request bits
    output logic                       cpu_reset,                // processor reset
    output logic                       brownout_irq,             // brownout irq pulse
    output logic                       cpu_clk_en,               // cpu clock enable
    output logic                       periph_clk_en,            // peripheral clock enable
    output logic                       osc_enable,               // main oscillator on
    output logic                       power_down_active,        // in power down
    output logic                       idle_active               // in idle
);

    // ----------------------------------------
    // brownout detection
    // ----------------------------------------
    logic bo_seen_ff;
    logic bo_live;
    logic bo_rise;
    logic bo_reset;

    // disable gates the detector out entirely
    assign bo_live  = brownout_detect && !auxiliary_control_one.brownout_disable; // RULE_11 RULE_20
    assign bo_rise  = bo_live && !bo_seen_ff;
    assign bo_reset = bo_live && !auxiliary_control_one.brownout_irq_select; // RULE_06 RULE_07 RULE_18

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bo_seen_ff <= 1'b0;
        end else begin
            bo_seen_ff <= bo_live;
        end
    end

    logic bo_irq_ff;

    // edge only, so a long sag gives one request
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bo_irq_ff <= 1'b0;
        end else begin
            bo_irq_ff <= bo_rise && auxiliary_control_one.brownout_irq_select; // RULE_06 RULE_08
        end
    end

    logic bo_irq_serviceable;
    assign bo_irq_serviceable = bo_irq_ff && interrupt_enable_zero.global_int_enable
                                && interrupt_enable_zero.brownout_int_enable; // RULE_09
    assign brownout_irq = bo_irq_serviceable;

    // ----------------------------------------
    // reset generation
    // ----------------------------------------
    logic rst_ff;

    // watchdog runs off its own oscillator, so it acts even in power down
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rst_ff <= 1'b1;
        end else begin
            rst_ff <= bo_reset || watchdog_overflow || power_on_detect; // RULE_07 RULE_17
        end
    end

    assign cpu_reset = rst_ff || bo_reset; // RULE_07 RULE_18

    // ----------------------------------------
    // power control flags
    // ----------------------------------------
    logic bo_flag_ff;
    logic po_flag_ff;

    // set beats a simultaneous software clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bo_flag_ff <= 1'b0;
        end else if (bo_live || power_on_detect) begin
            bo_flag_ff <= 1'b1; // RULE_10 RULE_23
        end else if (pctl_wr && !pctl_wdata[`CPM_PCTL_BROWNOUT_BIT]) begin
            bo_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            po_flag_ff <= 1'b0;
        end else if (power_on_detect) begin
            po_flag_ff <= 1'b1; // RULE_12
        end else if (pctl_wr && !pctl_wdata[`CPM_PCTL_POWER_ON_BIT]) begin
            po_flag_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // power reduction state machine
    // ----------------------------------------
    cpm_pkg::cpm_state_e state_ff;
    cpm_pkg::cpm_state_e nxt_state;
    logic [10:0]         wait_ff;
    logic [10:0]         wait_len;
    logic                req_idle;
    logic                req_down;
    logic                wake_src;
    logic                div_en;

    assign req_idle = pctl_wr && pctl_wdata[`CPM_PCTL_LIGHT_SLEEP_BIT];
    assign req_down = pctl_wr && pctl_wdata[`CPM_PCTL_DEEP_SLEEP_BIT];
    // brownout wakes only when configured as an interrupt and enabled
    assign wake_src = wake_irq_pending || bo_irq_serviceable; // RULE_16 RULE_18
    assign wait_len = osc_is_crystal ? `CPM_OSC_WAIT_CRYSTAL : `CPM_OSC_WAIT_RC;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            cpm_pkg::CPM_RUN: begin
                if (req_down) begin
                    nxt_state = cpm_pkg::CPM_DOWN; // RULE_15
                end else if (req_idle) begin
                    nxt_state = cpm_pkg::CPM_IDLE; // RULE_13
                end
            end
            cpm_pkg::CPM_IDLE: begin
                if (enabled_irq_pending || bo_irq_serviceable) begin
                    nxt_state = cpm_pkg::CPM_RUN; // RULE_14
                end
            end
            cpm_pkg::CPM_DOWN: begin
                if (wake_src) begin
                    nxt_state = cpm_pkg::CPM_WAKE; // RULE_16
                end
            end
            cpm_pkg::CPM_WAKE: begin
                if (wait_ff == 11'h001) begin
                    nxt_state = cpm_pkg::CPM_RUN; // RULE_19
                end
            end
        endcase
        if (cpu_reset) begin
            nxt_state = cpm_pkg::CPM_RUN; // RULE_14 RULE_16
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_ff <= cpm_pkg::CPM_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // oscillator restarts at once; cpu waits for the stability count
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wait_ff <= 11'h000;
        end else if (state_ff == cpm_pkg::CPM_DOWN && nxt_state == cpm_pkg::CPM_WAKE) begin
            wait_ff <= wait_len; // RULE_19
        end else if (state_ff == cpm_pkg::CPM_WAKE && wait_ff != 11'h000) begin
            wait_ff <= wait_ff - 11'h001;
        end
    end

    // ----------------------------------------
    // clock enables and outputs
    // ----------------------------------------
    // real silicon stops the oscillator; here the enables freeze instead
    assign osc_enable = (state_ff != cpm_pkg::CPM_DOWN); // RULE_15 RULE_19

    cpm_clk_div u_div (
        .sys_clk                 (sys_clk),
        .rst                     (rst),
        .run                     (osc_enable),
        .legacy_timing_select    (legacy_timing_select),
        .cpu_clock_divider_value (cpu_clock_divider_value),
        .cpu_clk_en              (div_en)
    );

    assign periph_clk_en     = div_en; // RULE_02 RULE_13
    assign cpu_clk_en        = div_en && (state_ff == cpm_pkg::CPM_RUN); // RULE_13 RULE_19
    assign power_down_active = (state_ff == cpm_pkg::CPM_DOWN);
    assign idle_active       = (state_ff == cpm_pkg::CPM_IDLE);

    // light request reads set in idle, deep request through power down and the wake wait; both clear on return to run
    always_comb begin
        pctl_status.brownout_flag       = bo_flag_ff;
        pctl_status.power_on_flag       = po_flag_ff;
        pctl_status.deep_sleep_request  = (state_ff == cpm_pkg::CPM_DOWN) || (state_ff == cpm_pkg::CPM_WAKE); // RULE_22
        pctl_status.light_sleep_request = (state_ff == cpm_pkg::CPM_IDLE); // RULE_22
    end

    always_comb begin
        power_control_reg = 8'h00;
        power_control_reg[`CPM_PCTL_BROWNOUT_BIT]    = pctl_status.brownout_flag; // RULE_23
        power_control_reg[`CPM_PCTL_POWER_ON_BIT]    = pctl_status.power_on_flag; // RULE_23
        power_control_reg[`CPM_PCTL_DEEP_SLEEP_BIT]  = pctl_status.deep_sleep_request;
        power_control_reg[`CPM_PCTL_LIGHT_SLEEP_BIT] = pctl_status.light_sleep_request;
    end

endmodule
`default_nettype wire

//--- dv/cpm_top_assertions.sv
// concurrent checks on the cpu clock and power manager ports
`timescale 1ns/1ps
`default_nettype none

module cpm_top_assertions (
    input wire logic               sys_clk,               // clock
    input wire logic               rst,                   // sync reset
    input wire logic               brownout_detect,       // detector level
    input wire logic               watchdog_overflow,     // watchdog pulse
    input wire cpm_pkg::cpm_aux_s  auxiliary_control_one, // brownout controls
    input wire cpm_pkg::cpm_ien_s  interrupt_enable_zero, // irq enables
    input wire logic               pctl_wr,               // write strobe
    input wire logic [7:0]         pctl_wdata,            // write data
    input wire logic [7:0]         power_control_reg,     // readback
    input wire cpm_pkg::cpm_pctl_s pctl_status,           // flag bits
    input wire logic               cpu_reset,             // reset out
    input wire logic               brownout_irq,          // irq out
    input wire logic               osc_enable,            // oscillator on
    input wire logic               power_down_active,     // power down
    input wire logic               idle_active            // idle
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_bo_rst;
        brownout_detect && !auxiliary_control_one.brownout_disable && !auxiliary_control_one.brownout_irq_select
            |-> cpu_reset;
    endproperty
    a_bo_rst: assert property (p_bo_rst) else $error("brownout did not hold reset");
    property p_irq_one;
        brownout_irq |=> !brownout_irq;
    endproperty
    a_irq_one: assert property (p_irq_one) else $error("brownout irq repeated");
    property p_irq_en;
        brownout_irq |-> interrupt_enable_zero.global_int_enable && interrupt_enable_zero.brownout_int_enable;
    endproperty
    a_irq_en: assert property (p_irq_en) else $error("brownout irq while disabled");
    property p_bo_off;
        auxiliary_control_one.brownout_disable && $past(auxiliary_control_one.brownout_disable) |-> !brownout_irq;
    endproperty
    a_bo_off: assert property (p_bo_off) else $error("brownout irq with detection off");
    property p_bo_flag_hold;
        pctl_status.brownout_flag && !pctl_wr |=> pctl_status.brownout_flag;
    endproperty
    a_bo_flag_hold: assert property (p_bo_flag_hold) else $error("brownout flag dropped");
    property p_map;
        power_control_reg[5:4] == {pctl_status.brownout_flag, pctl_status.power_on_flag};
    endproperty
    a_map: assert property (p_map) else $error("flag bit positions wrong");
    property p_down;
        pctl_wr && pctl_wdata[1] && !idle_active && !power_control_reg[1] && !cpu_reset
            |=> power_down_active && !osc_enable;
    endproperty
    a_down: assert property (p_down) else $error("power down not entered");
    property p_wdt;
        watchdog_overflow |=> cpu_reset;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog did not reset");
endmodule

bind cpm_top cpm_top_assertions u_chk (.*);

`default_nettype wire

//--- dv/cpm_top_test.sv
// self-checking bench for the cpu clock and power manager
`timescale 1ns/1ps
`default_nettype none

module cpm_top_test;
    logic               sys_clk = 1'h0, rst = 1'h1, power_on_detect = 1'h0, brownout_detect = 1'h0;
    logic               watchdog_overflow = 1'h0, osc_is_crystal = 1'h1, legacy_timing_select = 1'h0;
    logic               pctl_wr = 1'h0, enabled_irq_pending = 1'h0, wake_irq_pending = 1'h0, r;
    logic [7:0]         cpu_clock_divider_value = 8'h00, pctl_wdata = 8'h00, power_control_reg;
    cpm_pkg::cpm_aux_s  auxiliary_control_one = 2'h0;
    cpm_pkg::cpm_ien_s  interrupt_enable_zero = 2'h3;
    cpm_pkg::cpm_pctl_s pctl_status;
    logic               cpu_reset, brownout_irq, cpu_clk_en, periph_clk_en, osc_enable, power_down_active, idle_active;
    int                 failures = 0, checks = 0, cyc = 0, g, p, q;

    cpm_top DUT (.*);

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // helpers and reference model
    // ----------------------------------------
    task automatic test_done();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            test_done();
        end
    end
    task automatic chk(input logic c, input string m);
        checks++;
        if (c !== 1'h1) begin
            failures++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] d);
        pctl_wr = 1'h1;
        pctl_wdata = d;
        tick(1);
        pctl_wr = 1'h0;
    endtask
    task automatic do_reset();
        rst = 1'h1;
        tick(16);
        rst = 1'h0;
        tick(2);
    endtask
    // bounded so a dead clock enable cannot hang the run
    task automatic gap_to_en(output int k);
        k = 0;
        do begin
            tick(1);
            k++;
        end while (cpu_clk_en !== 1'h1 && k < 3000);
    endtask
    function automatic int exp_div(input int lg, input int nv);
        return (nv == 0 ? 1 : 2 * (nv + 1)) * (lg ? 2 : 1);
    endfunction

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        g = $urandom(22);
        tick(1);
        do_reset();
        for (int i = 0; i < 8; i++) begin
            legacy_timing_select = i[0];
            cpu_clock_divider_value = (i < 2) ? 8'h00 : (i < 4) ? 8'h01 : (i < 6) ? 8'hFF : 8'($urandom_range(254, 2));
            repeat (2) gap_to_en(g);
            gap_to_en(g);
            chk(g == exp_div(i % 2, cpu_clock_divider_value), "cpu clock gap");
        end
        legacy_timing_select = 1'h1;
        cpu_clock_divider_value = 8'h00;
        tick(4);
        p = 0;
        repeat (20) begin
            tick(1);
            p += periph_clk_en;
        end
        chk(p == 10, "peripheral clock rate");
        legacy_timing_select = 1'h0;
        $display("divider test done");
        brownout_detect = 1'h1;
        tick(5);
        chk(cpu_reset === 1'h1 && pctl_status.brownout_flag === 1'h1, "brownout reset");
        brownout_detect = 1'h0;
        tick(5);
        chk(cpu_reset === 1'h0 && power_control_reg[5] === 1'h1, "flag sticky");
        wr(8'h00);
        tick(1);
        chk(power_control_reg[5:4] === 2'h0, "flag clear");
        for (int k = 0; k < 3; k++) begin
            interrupt_enable_zero = (k == 1) ? 2'h2 : 2'h3;
            auxiliary_control_one = (k == 2) ? 2'h3 : 2'h1;
            tick(2);
            p = 0;
            r = 1'h0;
            brownout_detect = 1'h1;
            repeat (12) begin
                tick(1);
                p += brownout_irq;
                r |= cpu_reset;
            end
            brownout_detect = 1'h0;
            tick(2);
            chk(p == (k == 0) && r === 1'h0 && power_control_reg[5] === (k < 2), "brownout irq");
            wr(8'h00);
        end
        $display("brownout test done");
        power_on_detect = 1'h1;
        tick(1);
        power_on_detect = 1'h0;
        tick(20);
        chk(power_control_reg[5:4] === 2'h3 && pctl_status.power_on_flag === 1'h1, "power on flags");
        wr(8'h00);
        tick(1);
        chk(power_control_reg[4] === 1'h0, "power on flag clear");
        auxiliary_control_one = 2'h0;
        wr(8'h01);
        chk(idle_active === 1'h1 && power_control_reg[0] === 1'h1, "idle entry");
        chk(pctl_status.light_sleep_request === 1'h1, "idle request bit");
        p = 0;
        q = 0;
        repeat (6) begin
            tick(1);
            p += cpu_clk_en;
            q += periph_clk_en;
        end
        chk(p == 0 && q == 6, "idle clocks");
        enabled_irq_pending = 1'h1;
        tick(3);
        enabled_irq_pending = 1'h0;
        chk(idle_active === 1'h0 && power_control_reg[0] === 1'h0, "idle exit");
        for (int c = 1; c >= 0; c--) begin
            osc_is_crystal = c[0];
            wr(8'h02);
            chk(power_down_active === 1'h1 && osc_enable === 1'h0 && power_control_reg[1] === 1'h1, "down");
            chk(pctl_status.deep_sleep_request === 1'h1, "down request bit");
            tick(4);
            wake_irq_pending = 1'h1;
            tick(1);
            wake_irq_pending = 1'h0;
            gap_to_en(g);
            tick(1);
            chk(g >= (c ? 1024 : 256) && g <= (c ? 1027 : 259) && power_control_reg[1] === 1'h0, "wake");
        end
        for (int k = 0; k < 3; k++) begin
            auxiliary_control_one = {1'h0, k == 2};
            wr(8'h02);
            r = 1'h0;
            watchdog_overflow = (k == 0);
            brownout_detect = (k != 0);
            repeat (2) begin
                tick(1);
                r |= cpu_reset;
                watchdog_overflow = 1'h0;
            end
            brownout_detect = 1'h0;
            tick(2);
            chk(k == 2 ? power_down_active === 1'h0 : r === 1'h1, "down exit");
            do_reset();
        end
        // software side: leave low-power modes through reset, as after a retention-level supply
        wr(8'h01);
        do_reset();
        chk(idle_active === 1'h0 && power_control_reg[0] === 1'h0, "reset ends idle");
        wr(8'h02);
        do_reset();
        chk(power_down_active === 1'h0 && osc_enable === 1'h1, "reset ends down");
        $display("sleep test done");
        test_done();
    end
endmodule

`default_nettype wire
